/* hdl/cal_arith.sv */
/*
  Combinational transfer function of one channel with range clamp.
  Assumes operands are stable registers on the caller's clock.
*/
`timescale 1ns/100ps
module cal_arith (
  // Operands and result
  calc_if.unit calc
);
  wire [13:0] gain_plus = {1'b0, calc.gain} + 14'h0001;
  wire [27:0] product = calc.input_word * gain_plus;
  wire [14:0] scaled = product[27:cal_pkg::FRAC_SHIFT];
  wire signed [29:0] sum = $signed({15'h0000, scaled}) + $signed({16'h0000, calc.offset})
                           - $signed(cal_pkg::MID_OFFSET);
  wire under = sum[29];
  wire over = !under && (sum[28:14] != 15'h0000);
  assign calc.output_word = under ? cal_pkg::CODE_ZERO :
                            over ? cal_pkg::CODE_FULL : sum[13:0];
  assign calc.clamped = under | over;
endmodule : cal_arith

/* hdl/cal_datapath.sv */
/*
  Thirty-two channel calibration datapath with APB register access.
  Assumes a synchronous APB master and an external load request pin.
*/
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
// Function
// - code equals input times gain+1, shifted, plus offset minus midscale
// - input word 14 bits, midscale reset
// - gain 13 bits, all ones reset
// - offset 14 bits, midscale reset
// - output code resets to midscale
// - power-on gain full scale, offset 0x2000
// - clamp to full scale or zero
// - 32 channels, four groups of eight
// - each channel has three registers
// - output code selects string tap
// - recompute after writes, busy low meanwhile
// - load during busy remembered, applied after
`timescale 1ns/100ps
module cal_datapath (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Converter side
  input wire logic load_outputs_n_in,
  output logic busy_n_out,
  output logic [447:0] tap_code_out,
  output logic [31:0] ref2_select_out
);
  typedef enum logic [1:0] {IDLE, CALC, DONE} calc_state_e;

  function automatic logic [4:0] chan_of(input logic [11:0] a);
    chan_of = a[cal_pkg::CHAN_LSB +: cal_pkg::CH_BITS];
  endfunction : chan_of

  // Lowest pending channel first
  function automatic logic [4:0] pick(input logic [31:0] d);
    pick = 5'h00;
    for (int i = cal_pkg::CH_NUM - 1; i >= 0; i--) begin
      if (d[i]) begin
        pick = 5'(i);
      end
    end
  endfunction : pick

  function automatic logic [31:0] ref2_mask();
    ref2_mask = 32'h0000_0000;
    for (int i = 0; i < cal_pkg::CH_NUM; i++) begin
      ref2_mask[i] = (i % cal_pkg::GROUP_SIZE) >= cal_pkg::REF1_CHANNELS;
    end
  endfunction : ref2_mask
  localparam logic [31:0] REF2_MASK = ref2_mask();

  logic [13:0] input_q [cal_pkg::CH_NUM];
  logic [12:0] gain_q [cal_pkg::CH_NUM];
  logic [13:0] offset_q [cal_pkg::CH_NUM];
  logic [13:0] calc_q [cal_pkg::CH_NUM];
  logic [13:0] tap_q [cal_pkg::CH_NUM];
  logic [31:0] dirty_q;
  logic [4:0] cur_q;
  calc_state_e state_q;
  logic load_pend_q;
  logic ld_s1_q, ld_s2_q;
  logic busy_n_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [31:0] ref2_q;

  calc_if calc ();
  cal_arith u_arith (.calc(calc));

  wire access = psel_in && penable_in && !pready_q;
  wire [1:0] kind = paddr_in[cal_pkg::KIND_LSB +: 2];
  wire [4:0] wch = chan_of(paddr_in);
  wire aligned = (paddr_in[1:0] == 2'h0) && !paddr_in[7];
  wire is_status = paddr_in == cal_pkg::STATUS_ADDR;
  wire is_load = paddr_in == cal_pkg::LOAD_ADDR;
  wire is_chan = aligned && (kind != cal_pkg::KIND_MISC);
  wire wr_chan = access && pwrite_in && is_chan;
  wire bad = !(is_chan || is_status || (is_load && pwrite_in));
  wire sw_load = access && pwrite_in && is_load && pwdata_in[0];
  wire load_req = !ld_s2_q || sw_load;
  wire any_dirty = dirty_q != 32'h0000_0000;
  wire [4:0] next_ch = pick(dirty_q);
  wire [31:0] set_mask = wr_chan ? (32'h0000_0001 << wch) : 32'h0000_0000;
  wire [31:0] clr_mask = (state_q == CALC) ? (32'h0000_0001 << cur_q) : 32'h0000_0000;
  wire apply = (state_q == IDLE) && !any_dirty && (load_pend_q || load_req);
  wire [31:0] status_word = ({31'h0, ~busy_n_q} & cal_pkg::BUSY_BIT) |
                            ({30'h0, load_pend_q, 1'b0} & cal_pkg::PEND_BIT);
  wire [31:0] rd_chan = (kind == cal_pkg::KIND_INPUT) ? {18'h0, input_q[wch]} :
                        (kind == cal_pkg::KIND_GAIN) ? {19'h0, gain_q[wch]} :
                        {18'h0, offset_q[wch]};
  wire [31:0] rd_word = is_status ? status_word : (is_chan ? rd_chan : 32'h0);

  assign calc.input_word = input_q[cur_q];
  assign calc.gain = gain_q[cur_q];
  assign calc.offset = offset_q[cur_q];

  // Load pin synchroniser
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ld_s1_q <= 1'b1;
      ld_s2_q <= 1'b1;
    end else if (clk_en_in) begin
      ld_s1_q <= load_outputs_n_in;
      ld_s2_q <= ld_s1_q;
    end
  end

  // APB answer, one wait state
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      pready_q <= access;
      pslverr_q <= access && bad;
      if (access && !pwrite_in) begin
        prdata_q <= rd_word;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < cal_pkg::CH_NUM; i++) begin
        input_q[i] <= cal_pkg::INPUT_RESET;
        gain_q[i] <= cal_pkg::GAIN_RESET;
        offset_q[i] <= cal_pkg::OFFSET_RESET;
      end
    end else if (clk_en_in && wr_chan) begin
      case (kind)
        cal_pkg::KIND_INPUT: input_q[wch] <= pwdata_in[13:0];
        cal_pkg::KIND_GAIN: gain_q[wch] <= pwdata_in[12:0];
        default: offset_q[wch] <= pwdata_in[13:0];
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= IDLE;
      cur_q <= 5'h00;
      dirty_q <= 32'h0000_0000;
      busy_n_q <= 1'b1;
    end else if (clk_en_in) begin
      // A new write wins over the clear of the same channel
      dirty_q <= (dirty_q & ~clr_mask) | set_mask;
      case (state_q)
        IDLE: begin
          if (any_dirty) begin
            cur_q <= next_ch;
            state_q <= CALC;
            busy_n_q <= 1'b0;
          end
        end
        CALC: begin
          state_q <= DONE;
        end
        DONE: begin
          if (((dirty_q & ~clr_mask) | set_mask) != 32'h0000_0000) begin
            state_q <= IDLE;
          end else begin
            state_q <= IDLE;
            busy_n_q <= 1'b1;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < cal_pkg::CH_NUM; i++) begin
        calc_q[i] <= cal_pkg::OUTPUT_RESET;
        tap_q[i] <= cal_pkg::OUTPUT_RESET;
      end
      load_pend_q <= 1'b0;
    end else if (clk_en_in) begin
      if (state_q == CALC) begin
        calc_q[cur_q] <= calc.output_word;
      end
      if (apply) begin
        load_pend_q <= 1'b0;
        for (int i = 0; i < cal_pkg::CH_NUM; i++) begin
          tap_q[i] <= calc_q[i];
        end
      end else if (load_req) begin
        load_pend_q <= 1'b1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < cal_pkg::CH_NUM; i++) begin
      tap_code_out[i*cal_pkg::CODE_W +: cal_pkg::CODE_W] = tap_q[i];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref2_q <= REF2_MASK;
    end else if (clk_en_in) begin
      ref2_q <= REF2_MASK;
    end
  end

  assign ref2_select_out = ref2_q;
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign busy_n_out = busy_n_q;

  a_busy_on_calc: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q == CALC) |-> !busy_n_q)
    else $error("busy high during calculation");
  a_clamp_range: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state_q == CALC && u_arith.under) |=> calc_q[$past(cur_q)] == 14'h0000)
    else $error("underflow not clamped to zero");
  a_clamp_high: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state_q == CALC && u_arith.over) |=> calc_q[$past(cur_q)] == 14'h3FFF)
    else $error("overflow not clamped to full scale");
  a_no_apply_busy: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    apply |-> busy_n_q)
    else $error("outputs applied while busy");
  a_pend_applied: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && apply) |=> (tap_q[0] == $past(calc_q[0])))
    else $error("load lost");
  a_pend_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && load_req && !apply) |=> load_pend_q)
    else $error("blocked load not remembered");
  a_pend_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && apply) |=> !load_pend_q)
    else $error("pending load kept after update");
  a_tap_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(clk_en_in && apply) |=> $stable(tap_code_out))
    else $error("tap code changed without load");
  a_write_dirty: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && wr_chan) |=> dirty_q[$past(wch)])
    else $error("write not scheduled");
  a_busy_follows: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && wr_chan) |-> ##[1:1000] !busy_n_q)
    else $error("write without busy pulse");
  a_busy_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state_q == DONE && !any_dirty && !wr_chan) |=> busy_n_q)
    else $error("busy kept after last channel");
  a_freeze_state: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !clk_en_in |=> $stable(state_q) && $stable(dirty_q) && $stable(busy_n_q)
      && $stable(tap_code_out))
    else $error("state moved while clock enable low");
  a_store_code: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state_q == CALC) |=> calc_q[$past(cur_q)] == $past(calc.output_word))
    else $error("code not stored");
  a_apb_ready: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && access) |=> pready_q)
    else $error("no ready");
  a_pready_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (clk_en_in && pready_q) |=> !pready_q)
    else $error("ready longer than one cycle");
  a_slverr_ready: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pslverr_q |-> pready_q)
    else $error("error response without ready");
  a_ref_pair: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ref2_select_out == 32'hC0C0_C0C0)
    else $error("reference grouping wrong");
endmodule : cal_datapath

/* inc/cal_pkg.sv */
/*
  Constants for the per-channel gain and offset calibration datapath:
  register map, field widths, reset values and channel organisation.
  Assumes a 32-bit APB register bus.
*/
package cal_pkg;
  localparam int CH_NUM = 32;
  localparam int CH_BITS = 5;
  localparam int GROUP_SIZE = 8;
  localparam int REF1_CHANNELS = 6;
  localparam int CODE_W = 14;
  localparam int GAIN_W = 13;
  localparam int FRAC_SHIFT = 13;
  localparam int PROD_W = 28;
  localparam int SUM_W = 30;
  localparam logic [13:0] INPUT_RESET = 14'h2000;
  localparam logic [12:0] GAIN_RESET = 13'h1FFF;
  localparam logic [13:0] OFFSET_RESET = 14'h2000;
  localparam logic [13:0] OUTPUT_RESET = 14'h2000;
  localparam logic [13:0] CODE_FULL = 14'h3FFF;
  localparam logic [13:0] CODE_ZERO = 14'h0000;
  localparam logic [29:0] MID_OFFSET = 30'h0000_2000;
  // Byte address layout: [9:8] register kind, [6:2] channel
  localparam logic [1:0] KIND_INPUT = 2'h0;
  localparam logic [1:0] KIND_GAIN = 2'h1;
  localparam logic [1:0] KIND_OFFSET = 2'h2;
  localparam logic [1:0] KIND_MISC = 2'h3;
  localparam logic [11:0] STATUS_ADDR = 12'h300;
  localparam logic [11:0] LOAD_ADDR = 12'h304;
  localparam int KIND_LSB = 8;
  localparam int CHAN_LSB = 2;
  localparam int ADDR_W = 12;
  localparam logic [31:0] BUSY_BIT = 32'h0000_0001;
  localparam logic [31:0] PEND_BIT = 32'h0000_0002;
endpackage : cal_pkg

/* inc/calc_if.sv */
/*
  Request and result carrier between the register file and the
  arithmetic unit. Same clock on both sides.
*/
`timescale 1ns/100ps
interface calc_if;
  logic [13:0] input_word;
  logic [12:0] gain;
  logic [13:0] offset;
  logic [13:0] output_word;
  logic clamped;
  modport master (output input_word, output gain, output offset,
                  input output_word, input clamped);
  modport unit (input input_word, input gain, input offset,
                output output_word, output clamped);
endinterface : calc_if

/* sim/cal_datapath_tb.sv */
/*
  Testbench: register access, transfer function, clamps and load timing.
  Assumes the APB host model and a free-running 125 MHz clock.
*/
`timescale 1ns/100ps
module cal_datapath_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic load_n = 1'b1;
  logic clk_en = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, busy_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ref2;
  logic [447:0] tap;
  int mismatches = 0;
  int cmp_count = 0;
  int cch[4] = '{3, 7, 8, 31};
  int cx[4] = '{'h1000, 'h3FFF, 0, 'h3FFF};
  int cm[4] = '{'h0FFF, 'h1FFF, 'h1FFF, 0};
  int cc[4] = '{'h2010, 'h3FFF, 0, 'h2005};
  always #4 clk = ~clk;
  host_model u_host (.clk_in(clk), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
  cal_datapath u_cal_datapath (.ref_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .load_outputs_n_in(load_n), .busy_n_out(busy_n),
    .tap_code_out(tap), .ref2_select_out(ref2));
  task automatic stop_test;
    if (mismatches == 0 && u_host.timeouts == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    u_host.xfer(a, 1'b1, d, r, er);
    if (u_host.timeouts != 0) begin
      mismatches++;
      stop_test();
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic er;
    u_host.xfer(a, 1'b0, 32'h0, r, er);
    if (u_host.timeouts != 0) begin
      mismatches++;
      stop_test();
    end
    if (!ee) chk("prdata", e, r);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask : rd
  task automatic wait_idle;
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    repeat (8) @(posedge clk) if (busy_n === 1'b0) seen = 1'b1;
    chk("busy_n low", 32'h1, {31'h0, seen});
    while (busy_n !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (busy_n !== 1'b1) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_idle
  task automatic chk_tap(input int ch, input logic [13:0] e);
    int n;
    n = 0;
    while (tap[14*ch +: 14] !== e && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk("tap", {18'h0, e}, {18'h0, tap[14*ch +: 14]});
  endtask : chk_tap
  function automatic logic [13:0] calc(input int x, input int m, input int c);
    longint s;
    s = ((longint'(x) * (m + 1)) >>> 13) + c - 8192;
    return (s > 16383) ? 14'h3FFF : (s < 0) ? 14'h0000 : s[13:0];
  endfunction : calc
  task automatic set_ch(input int i);
    wr(12'(4 * cch[i]), 32'(cx[i]));
    wr(12'h100 + 12'(4 * cch[i]), 32'(cm[i]));
    wr(12'h200 + 12'(4 * cch[i]), 32'(cc[i]));
    wait_idle();
    wr(cal_pkg::LOAD_ADDR, 32'h1);
    chk_tap(cch[i], calc(cx[i], cm[i], cc[i]));
  endtask : set_ch
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chk_tap(0, 14'h2000);
    chk_tap(31, 14'h2000);
    chk("ref2", 32'hC0C0_C0C0, ref2);
    rd(12'h000, 32'h2000, 1'b0);
    rd(12'h114, 32'h1FFF, 1'b0);
    rd(12'h27C, 32'h2000, 1'b0);
    rd(cal_pkg::STATUS_ADDR, 32'h0, 1'b0);
    rd(12'h308, 32'h0, 1'b1);
    for (int i = 0; i < 4; i++) set_ch(i);
    rd(12'h00C, 32'h1000, 1'b0);
    rd(12'h110, 32'h1FFF, 1'b0);
    chk_tap(4, 14'h2000);
    chk_tap(3, calc('h1000, 'h0FFF, 'h2010));
    // Load pin pulse lands while busy is low
    fork
      wr(12'h00C, 32'h0C00);
      begin
        repeat (2) @(posedge clk);
        load_n <= 1'b0;
        @(posedge clk);
        load_n <= 1'b1;
      end
    join
    wait_idle();
    chk_tap(3, calc('h0C00, 'h0FFF, 'h2010));
    wr(12'h00C, 32'h0800);
    load_n <= 1'b0;
    wait_idle();
    chk_tap(3, calc('h0800, 'h0FFF, 'h2010));
    load_n <= 1'b1;
    // Load pin ignored while the clock enable is low
    wr(12'h00C, 32'h0400);
    wait_idle();
    clk_en <= 1'b0;
    load_n <= 1'b0;
    repeat (6) @(posedge clk);
    load_n <= 1'b1;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk);
    chk_tap(3, calc('h0800, 'h0FFF, 'h2010));
    wr(cal_pkg::LOAD_ADDR, 32'h1);
    chk_tap(3, calc('h0400, 'h0FFF, 'h2010));
    stop_test();
  end
endmodule : cal_datapath_tb

/* sim/host_model.sv */
/*
  Host model: APB master that writes and reads the calibration registers.
  Assumes one clock shared with the datapath and no wait limit beyond its own.
*/
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clk_in,
  // APB master
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  int timeouts = 0;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
  end
  task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 50);
    if (pready_in !== 1'b1) timeouts++;
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask : xfer
endmodule : host_model
